// *** verilog/albx_cfg.svh ***
`ifndef ALBX_CFG_SVH
`define ALBX_CFG_SVH
// ----------------------------------------
// cycle counts per instruction class
// ----------------------------------------
`define ALBX_CYC_ONE 3'd1
`define ALBX_CYC_TWO 3'd2
`define ALBX_CYC_RELATIVE_SUB_CALL 3'd4
`define ALBX_CYC_SUB_CALL_VIA_POINTER 3'd4
`define ALBX_CYC_CALL 3'd5
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define ALBX_F_C 0
`define ALBX_F_Z 1
`define ALBX_F_N 2
`define ALBX_F_V 3
`define ALBX_F_S 4
`define ALBX_F_H 5
// ----------------------------------------
// constants
// ----------------------------------------
`define ALBX_BYTE_ONES 8'hff
`define ALBX_SREG_RST 8'h00
`endif

// *** verilog/albx_pkg.sv ***
package albx_pkg;
  typedef enum logic [5:0] {
    ALBX_ADD, ALBX_ADC, ALBX_WORD_ADD_IMM, ALBX_SUB, ALBX_SUB_CONST, ALBX_SUB_BORROW_REG,
    ALBX_SUB_BORROW_CONST, ALBX_WORD_SUB_IMM, ALBX_AND, ALBX_AND_CONST, ALBX_OR, ALBX_OR_CONST,
    ALBX_XOR_REGS, ALBX_BITS_SET_OP, ALBX_BITS_CLEAR_OP, ALBX_INC, ALBX_MINUS_ONE_OP,
    ALBX_PRODUCT_UNSIGNED, ALBX_PRODUCT_SIGNED, ALBX_PRODUCT_MIXED, ALBX_FRAC_PRODUCT_UNSIGNED,
    ALBX_FRAC_PRODUCT_SIGNED, ALBX_FRAC_PRODUCT_MIXED, ALBX_RELATIVE_SUB_CALL, ALBX_JUMP_VIA_POINTER,
    ALBX_FAR_JUMP_VIA_POINTER, ALBX_SUB_CALL_VIA_POINTER, ALBX_FAR_SUB_CALL_VIA_POINTER, ALBX_CALL,
    ALBX_EQUAL_SKIP_OP, ALBX_COMPARE, ALBX_COMPARE_WITH_BORROW, ALBX_COMPARE_CONST
  } albx_op_e;
  typedef enum logic [1:0] {ALBX_IDLE, ALBX_BUSY} albx_state_e;
  typedef struct packed {
    albx_op_e op;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [7:0] k;
    logic [15:0] word;
    logic [15:0] zptr;
    logic [5:0] jump_page;
    logic [21:0] pc;
    logic [21:0] abs_addr;
    logic next_two_word;
  } albx_req_s;
  typedef struct packed {
    logic wr_rd;
    logic [7:0] rd_val;
    logic wr_word;
    logic [15:0] word_val;
    logic wr_product_pair;
    logic [15:0] product_val;
    logic pc_load;
    logic [21:0] pc_val;
  } albx_res_s;
  typedef struct packed {
    albx_state_e state;
    logic [2:0] cnt;
    logic done;
    logic [7:0] sreg;
    albx_res_s res;
  } albx_st_s;
endpackage : albx_pkg

// *** verilog/albx_exec.sv ***
`include "albx_cfg.svh"
// Behaviour
// - add and add-with-carry write the sum, update Z C N V H, one cycle.
// - word add/sub immediate on 16-bit pair, update Z C N V S, two cycles.
// - subtract reg/const, with or without borrow, update Z C N V H, one cycle.
// - and, or in reg and const forms, xor in reg form, set only Z N V, one cycle.
// - bit set ors mask, bit clear ands inverted mask; Z N V; one cycle.
// - increment and decrement by one, Z N V only, carry kept, one cycle.
// - three multiplies write 16-bit product to product pair, Z and C, two cycles.
// - fractional multiplies take C from the unshifted product, then shift it left one for Z and the write, two cycles.
// - relative call loads pc plus offset plus one, no flags, four cycles.
// - pointer jump loads pc from Z, no flags, two cycles.
// - far pointer jump loads page register above Z, no flags, two cycles.
// - pointer calls, near or far, load target, no flags, four cycles.
// - direct call loads absolute address, no flags, five cycles.
// - equal skip advances pc by two or three when equal, 1/2/3 cycles, no flags.
// - compares subtract for flags only, write nothing, one cycle.
module albx_exec
  import albx_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request from decoder
  input wire logic req_valid,
  input albx_req_s req,
  output logic req_ready,
  // results
  output logic done,
  output albx_res_s res,
  output logic [7:0] sreg
);
  albx_st_s st_reg, st_next;

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  logic [7:0] a, b, r8;
  logic [8:0] sum9;
  logic cin, is_sub, is_add, is_logic, is_incdec, is_word, is_mul;
  logic [16:0] w17;
  logic [15:0] prod;
  logic signed [17:0] sprod;
  logic [2:0] cyc;
  logic [7:0] f;
  albx_res_s r;

  always_comb begin
    a = req.rd;
    b = req.rr;
    cin = 1'b0;
    is_sub = 1'b0;
    is_add = 1'b0;
    is_logic = 1'b0;
    is_incdec = 1'b0;
    is_word = 1'b0;
    is_mul = 1'b0;
    r8 = 8'h00;
    sum9 = 9'h000;
    w17 = 17'h00000;
    sprod = 18'sh00000;
    prod = 16'h0000;
    cyc = `ALBX_CYC_ONE;
    r = '0;
    f = st_reg.sreg;
    case (req.op)
      ALBX_ADD, ALBX_ADC: begin
        is_add = 1'b1;
        cin = (req.op == ALBX_ADC) & st_reg.sreg[`ALBX_F_C];
      end
      ALBX_SUB, ALBX_SUB_BORROW_REG, ALBX_COMPARE, ALBX_COMPARE_WITH_BORROW: begin
        is_sub = 1'b1;
        cin = (req.op == ALBX_SUB_BORROW_REG || req.op == ALBX_COMPARE_WITH_BORROW) & st_reg.sreg[`ALBX_F_C];
      end
      ALBX_SUB_CONST, ALBX_SUB_BORROW_CONST, ALBX_COMPARE_CONST: begin
        is_sub = 1'b1;
        b = req.k;
        cin = (req.op == ALBX_SUB_BORROW_CONST) & st_reg.sreg[`ALBX_F_C];
      end
      ALBX_AND, ALBX_XOR_REGS, ALBX_OR: is_logic = 1'b1;
      ALBX_AND_CONST, ALBX_OR_CONST, ALBX_BITS_SET_OP: begin
        is_logic = 1'b1;
        b = req.k;
      end
      ALBX_BITS_CLEAR_OP: begin
        is_logic = 1'b1;
        b = `ALBX_BYTE_ONES - req.k;
      end
      ALBX_INC, ALBX_MINUS_ONE_OP: is_incdec = 1'b1;
      ALBX_WORD_ADD_IMM, ALBX_WORD_SUB_IMM: is_word = 1'b1;
      default: is_mul = 1'b0;
    endcase
    if (is_add) begin
      sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      r8 = sum9[7:0];
      f[`ALBX_F_C] = sum9[8];
      f[`ALBX_F_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
      f[`ALBX_F_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
    end else if (is_sub) begin
      sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      r8 = sum9[7:0];
      f[`ALBX_F_C] = sum9[8];
      f[`ALBX_F_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
      f[`ALBX_F_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
    end else if (is_logic) begin
      if (req.op == ALBX_AND || req.op == ALBX_AND_CONST || req.op == ALBX_BITS_CLEAR_OP) begin
        r8 = a & b;
      end else if (req.op == ALBX_XOR_REGS) begin
        r8 = a ^ b;
      end else begin
        r8 = a | b;
      end
      f[`ALBX_F_V] = 1'b0;
    end else if (is_incdec) begin
      r8 = (req.op == ALBX_INC) ? a + 8'h01 : a - 8'h01;
      f[`ALBX_F_V] = (req.op == ALBX_INC) ? (a == 8'h7f) : (a == 8'h80);
    end
    if (is_add || is_sub || is_logic || is_incdec) begin
      f[`ALBX_F_N] = r8[7];
      f[`ALBX_F_Z] = (r8 == 8'h00);
      // subtract-with-borrow and borrow-compare keep Z when result is zero
      if (req.op == ALBX_SUB_BORROW_REG || req.op == ALBX_SUB_BORROW_CONST || req.op == ALBX_COMPARE_WITH_BORROW) begin
        f[`ALBX_F_Z] = (r8 == 8'h00) & st_reg.sreg[`ALBX_F_Z];
      end
      // byte ops leave the sign flag alone, only word ops touch it
      r.wr_rd = ~(req.op inside {ALBX_COMPARE, ALBX_COMPARE_WITH_BORROW, ALBX_COMPARE_CONST});
      r.rd_val = r8;
    end
    if (is_word) begin
      cyc = `ALBX_CYC_TWO;
      if (req.op == ALBX_WORD_ADD_IMM) begin
        w17 = {1'b0, req.word} + {9'h000, req.k};
        f[`ALBX_F_V] = ~req.word[15] & w17[15];
        f[`ALBX_F_C] = ~w17[15] & req.word[15];
      end else begin
        w17 = {1'b0, req.word} - {9'h000, req.k};
        f[`ALBX_F_V] = req.word[15] & ~w17[15];
        f[`ALBX_F_C] = w17[15] & ~req.word[15];
      end
      f[`ALBX_F_N] = w17[15];
      f[`ALBX_F_Z] = (w17[15:0] == 16'h0000);
      f[`ALBX_F_S] = f[`ALBX_F_N] ^ f[`ALBX_F_V];
      r.wr_word = 1'b1;
      r.word_val = w17[15:0];
    end
    // ----------------------------------------
    // multiplier
    // ----------------------------------------
    case (req.op)
      ALBX_PRODUCT_UNSIGNED, ALBX_FRAC_PRODUCT_UNSIGNED: begin
        sprod = $signed({1'b0, a}) * $signed({1'b0, b});
        is_mul = 1'b1;
      end
      ALBX_PRODUCT_SIGNED, ALBX_FRAC_PRODUCT_SIGNED: begin
        sprod = $signed({a[7], a}) * $signed({b[7], b});
        is_mul = 1'b1;
      end
      ALBX_PRODUCT_MIXED, ALBX_FRAC_PRODUCT_MIXED: begin
        sprod = $signed({a[7], a}) * $signed({1'b0, b});
        is_mul = 1'b1;
      end
      default: sprod = 18'sh00000;
    endcase
    if (is_mul) begin
      cyc = `ALBX_CYC_TWO;
      prod = sprod[15:0];
      f[`ALBX_F_C] = prod[15];
      if (req.op == ALBX_FRAC_PRODUCT_UNSIGNED || req.op == ALBX_FRAC_PRODUCT_SIGNED
          || req.op == ALBX_FRAC_PRODUCT_MIXED) begin
        prod = {sprod[14:0], 1'b0};
      end
      f[`ALBX_F_Z] = (prod == 16'h0000);
      r.wr_product_pair = 1'b1;
      r.product_val = prod;
    end
    // ----------------------------------------
    // program flow, flags untouched
    // ----------------------------------------
    case (req.op)
      ALBX_RELATIVE_SUB_CALL: begin
        r.pc_load = 1'b1;
        r.pc_val = req.pc + {{14{req.k[7]}}, req.k} + 22'd1;
        cyc = `ALBX_CYC_RELATIVE_SUB_CALL;
      end
      ALBX_JUMP_VIA_POINTER: begin
        r.pc_load = 1'b1;
        r.pc_val = {6'h00, req.zptr};
        cyc = `ALBX_CYC_TWO;
      end
      ALBX_FAR_JUMP_VIA_POINTER: begin
        r.pc_load = 1'b1;
        r.pc_val = {req.jump_page, req.zptr};
        cyc = `ALBX_CYC_TWO;
      end
      ALBX_SUB_CALL_VIA_POINTER, ALBX_FAR_SUB_CALL_VIA_POINTER: begin
        r.pc_load = 1'b1;
        r.pc_val = (req.op == ALBX_FAR_SUB_CALL_VIA_POINTER) ? {req.jump_page, req.zptr}
                                                             : {6'h00, req.zptr};
        cyc = `ALBX_CYC_SUB_CALL_VIA_POINTER;
      end
      ALBX_CALL: begin
        r.pc_load = 1'b1;
        r.pc_val = req.abs_addr;
        cyc = `ALBX_CYC_CALL;
      end
      ALBX_EQUAL_SKIP_OP: begin
        r.pc_load = 1'b1;
        if (req.rd == req.rr) begin
          r.pc_val = req.pc + (req.next_two_word ? 22'd3 : 22'd2);
          cyc = req.next_two_word ? 3'd3 : 3'd2;
        end else begin
          r.pc_val = req.pc + 22'd1;
        end
      end
      default: r.pc_load = 1'b0;
    endcase
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  assign req_ready = (st_reg.state == ALBX_IDLE);

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      ALBX_IDLE: begin
        if (req_valid) begin
          st_next.res = r;
          st_next.sreg = f;
          if (cyc == `ALBX_CYC_ONE) begin
            st_next.done = 1'b1;
          end else begin
            st_next.state = ALBX_BUSY;
            st_next.cnt = cyc - 3'd1;
          end
        end
      end
      default: begin
        st_next.cnt = st_reg.cnt - 3'd1;
        if (st_reg.cnt == 3'd1) begin
          st_next.state = ALBX_IDLE;
          st_next.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{state: ALBX_IDLE, cnt: 3'd0, done: 1'b0, sreg: `ALBX_SREG_RST, res: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;
  assign res = st_reg.res;
  assign sreg = st_reg.sreg;
endmodule : albx_exec

// *** testbench/albx_exec_properties.sv ***
module albx_exec_properties
  import albx_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request
  input wire logic req_valid,
  input albx_req_s req,
  input wire logic req_ready,
  // results
  input wire logic done,
  input albx_res_s res,
  input wire logic [7:0] sreg
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic tk;
  assign tk = req_valid && req_ready;
  a_add_sum: assert property (tk && req.op == ALBX_ADD |=> done && res.rd_val == $past(req.rd) + $past(req.rr))
    else $error("add sum wrong");
  a_word_two: assert property (tk && req.op inside {ALBX_WORD_ADD_IMM, ALBX_WORD_SUB_IMM} |=>
    !req_ready && !done ##1 done && res.wr_word) else $error("word op timing wrong");
  a_logic_vclear: assert property (tk && req.op inside {ALBX_AND, ALBX_OR, ALBX_XOR_REGS} |=>
    done && !sreg[3] && (sreg & 8'h31) == ($past(sreg) & 8'h31)) else $error("logic flags wrong");
  a_step_carry: assert property (tk && req.op inside {ALBX_INC, ALBX_MINUS_ONE_OP} |=>
    done && (sreg & 8'h31) == ($past(sreg) & 8'h31)) else $error("step touched carry");
  a_mul_pair: assert property (tk && req.op == ALBX_PRODUCT_UNSIGNED |=> !done ##1
    done && res.product_val == $past(req.rd, 2) * $past(req.rr, 2)) else $error("product wrong");
  a_ptr_jump: assert property (tk && req.op == ALBX_JUMP_VIA_POINTER |=> !done ##1
    done && res.pc_val == {6'h00, $past(req.zptr, 2)}) else $error("pointer jump wrong");
  a_call_four: assert property (tk && req.op inside {ALBX_RELATIVE_SUB_CALL, ALBX_SUB_CALL_VIA_POINTER} |=>
    !done [*3] ##1 done && sreg == $past(sreg, 4)) else $error("call timing wrong");
  a_call_five: assert property (tk && req.op == ALBX_CALL |=> !done [*4] ##1 done)
    else $error("direct call timing wrong");
  a_cmp_nowrite: assert property (tk && req.op inside {[ALBX_COMPARE:ALBX_COMPARE_CONST]} |=>
    done && !res.wr_rd && !res.wr_word && !res.wr_product_pair && !res.pc_load) else $error("compare wrote");
  c_call: cover property (tk && req.op == ALBX_CALL);
  c_skip: cover property (tk && req.op == ALBX_EQUAL_SKIP_OP && req.rd == req.rr);
  c_b2b: cover property (done && tk);
endmodule : albx_exec_properties

bind albx_exec albx_exec_properties albx_exec_properties_inst (.core_clk(core_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .res(res), .sreg(sreg));

// *** testbench/tb_albx_exec.sv ***
module tb_albx_exec
  import albx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, req_valid = 0, req_ready, done;
  albx_req_s req = '0;
  albx_res_s res;
  logic [7:0] sreg, es = 8'h00;
  int seed = 58270, n_mismatch = 0, compares = 0, cyc = 0;
  albx_exec albx_exec_inst (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .res(res), .sreg(sreg));
  // ----
  // helpers
  // ----
  initial forever #2 core_clk = ~core_clk;
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic void model(input albx_req_s q, inout logic [7:0] f, output logic [21:0] v,
    output int n, output int s);
    logic [8:0] r;
    logic [4:0] h;
    logic [16:0] w;
    logic [15:0] p, x, y;
    logic [7:0] a, b;
    logic c, u, k;
    a = q.rd;
    b = q.op inside {ALBX_SUB_CONST, ALBX_SUB_BORROW_CONST, ALBX_AND_CONST, ALBX_OR_CONST, ALBX_BITS_SET_OP,
      ALBX_COMPARE_CONST} ? q.k : q.rr;
    u = !(q.op inside {ALBX_ADD, ALBX_ADC});
    k = q.op inside {ALBX_SUB_BORROW_REG, ALBX_SUB_BORROW_CONST, ALBX_COMPARE_WITH_BORROW};
    c = (k || q.op == ALBX_ADC) && f[0];
    n = 1;
    s = 0;
    r = 0;
    case (q.op)
      ALBX_ADD, ALBX_ADC, ALBX_SUB, ALBX_SUB_CONST, ALBX_SUB_BORROW_REG, ALBX_SUB_BORROW_CONST, ALBX_COMPARE,
      ALBX_COMPARE_WITH_BORROW, ALBX_COMPARE_CONST: begin
        r = u ? {1'b0, a} - b - c : {1'b0, a} + b + c;
        h = u ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
        f[0] = r[8];
        f[5] = h[4];
        f[3] = ((a[7] ^ b[7]) == u) && (r[7] != a[7]);
        f[1] = r[7:0] == 0 && (!k || f[1]);
        f[2] = r[7];
        if (q.op inside {ALBX_COMPARE, ALBX_COMPARE_WITH_BORROW, ALBX_COMPARE_CONST}) s = 4;
      end
      ALBX_AND, ALBX_AND_CONST: r = {1'b0, a & b};
      ALBX_OR, ALBX_OR_CONST, ALBX_BITS_SET_OP: r = {1'b0, a | b};
      ALBX_XOR_REGS: r = {1'b0, a ^ b};
      ALBX_BITS_CLEAR_OP: r = {1'b0, a & (8'hff - q.k)};
      ALBX_INC: r = {1'b0, a + 8'h01};
      ALBX_MINUS_ONE_OP: r = {1'b0, a - 8'h01};
      default: ;
    endcase
    if (q.op inside {[ALBX_AND:ALBX_MINUS_ONE_OP]}) begin
      f[1] = r[7:0] == 0;
      f[2] = r[7];
      f[3] = q.op == ALBX_INC ? r[7:0] == 8'h80 : q.op == ALBX_MINUS_ONE_OP && r[7:0] == 8'h7f;
    end
    v = {14'h0000, r[7:0]};
    if (q.op inside {[ALBX_RELATIVE_SUB_CALL:ALBX_EQUAL_SKIP_OP]}) s = 3;
    n = q.op == ALBX_CALL ? 5 : q.op inside {[ALBX_JUMP_VIA_POINTER:ALBX_FAR_JUMP_VIA_POINTER]} ? 2 : s == 3 ? 4 : n;
    case (q.op)
      ALBX_WORD_ADD_IMM, ALBX_WORD_SUB_IMM: begin
        u = q.op == ALBX_WORD_SUB_IMM;
        w = u ? {1'b0, q.word} - q.k : {1'b0, q.word} + q.k;
        f[0] = w[16];
        f[1] = w[15:0] == 0;
        f[2] = w[15];
        f[3] = (q.word[15] == u) && (w[15] != q.word[15]);
        f[4] = f[2] ^ f[3];
        n = 2;
        s = 1;
        v = {6'h00, w[15:0]};
      end
      ALBX_PRODUCT_UNSIGNED, ALBX_PRODUCT_SIGNED, ALBX_PRODUCT_MIXED, ALBX_FRAC_PRODUCT_UNSIGNED,
      ALBX_FRAC_PRODUCT_SIGNED, ALBX_FRAC_PRODUCT_MIXED: begin
        x = q.op inside {ALBX_PRODUCT_UNSIGNED, ALBX_FRAC_PRODUCT_UNSIGNED} ? {8'h00, a} : {{8{a[7]}}, a};
        y = q.op inside {ALBX_PRODUCT_SIGNED, ALBX_FRAC_PRODUCT_SIGNED} ? {{8{b[7]}}, b} : {8'h00, b};
        p = x * y;
        f[0] = p[15];
        if (q.op >= ALBX_FRAC_PRODUCT_UNSIGNED) p = p << 1;
        f[1] = p == 0;
        n = 2;
        s = 2;
        v = {6'h00, p};
      end
      ALBX_RELATIVE_SUB_CALL: v = q.pc + {{14{q.k[7]}}, q.k} + 22'h1;
      ALBX_JUMP_VIA_POINTER, ALBX_SUB_CALL_VIA_POINTER: v = {6'h00, q.zptr};
      ALBX_FAR_JUMP_VIA_POINTER, ALBX_FAR_SUB_CALL_VIA_POINTER: v = {q.jump_page, q.zptr};
      ALBX_CALL: v = q.abs_addr;
      ALBX_EQUAL_SKIP_OP: begin
        n = a != b ? 1 : q.next_two_word ? 3 : 2;
        v = q.pc + 22'(n);
      end
      default: ;
    endcase
  endfunction : model
  task automatic run(input albx_op_e op, input bit fix, input logic [15:0] ab);
    albx_req_s q;
    logic [127:0] x;
    logic [21:0] v, g;
    int n, s, t;
    x = {$random(seed), $random(seed), $random(seed), $random(seed)};
    q = x[112:0];
    q.op = op;
    if (op inside {ALBX_WORD_ADD_IMM, ALBX_WORD_SUB_IMM}) q.k[7:6] = 2'b00;
    if (fix) begin
      {q.rd, q.rr} = ab;
      q.word = ab;
      q.k = 8'h01;
    end
    @(negedge core_clk);
    chk("req_ready", 22'h1, {21'h0, req_ready});
    req_valid = 1;
    req = q;
    @(posedge core_clk);
    model(q, es, v, n, s);
    @(negedge core_clk);
    req_valid = 0;
    t = 1;
    while (done !== 1'b1 && t < 8) begin
      @(negedge core_clk);
      t++;
    end
    g = s == 0 ? {14'h0, res.rd_val} : s == 1 ? {6'h0, res.word_val} : s == 2 ? {6'h0, res.product_val} : res.pc_val;
    chk("cycles", 22'(n), 22'(t));
    chk("sreg", {14'h0, es}, {14'h0, sreg});
    chk("writes", 22'(4'b1000 >> s), {18'h0, res.wr_rd, res.wr_word, res.wr_product_pair, res.pc_load});
    if (s < 4) chk("value", v, g);
  endtask : run
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1;
    chk("sreg_rst", 22'h0, {14'h0, sreg});
    run(ALBX_ADD, 1, 16'h7f01);
    run(ALBX_SUB, 1, 16'h0001);
    run(ALBX_SUB_BORROW_REG, 1, 16'h0000);
    run(ALBX_COMPARE_WITH_BORROW, 1, 16'h0000);
    run(ALBX_COMPARE_CONST, 1, 16'h0100);
    run(ALBX_XOR_REGS, 1, 16'h5a5a);
    run(ALBX_INC, 1, 16'h7f00);
    run(ALBX_MINUS_ONE_OP, 1, 16'h8000);
    run(ALBX_WORD_ADD_IMM, 1, 16'hffff);
    run(ALBX_WORD_SUB_IMM, 1, 16'h0000);
    run(ALBX_FRAC_PRODUCT_SIGNED, 1, 16'h8080);
    run(ALBX_EQUAL_SKIP_OP, 1, 16'h3333);
    for (int i = 0; i < 33; i++) run(albx_op_e'(i), 0, 16'h0);
    for (int i = 0; i < 1500; i++) run(albx_op_e'(6'($unsigned($random(seed)) % 33)), 0, 16'h0);
    finish_test();
  end
endmodule : tb_albx_exec
